// ---- shared/lcdsc_pkg.sv ----
// How it works
// - Read frame: 110, address, device returns nibble
// - Write frame: 101, address high-first, data low-first
// - Read-modify-write: 101, read out then store
// - Commands: 100 then nine bits, ID once
// - Code 0000-0000 stops oscillator and bias
// - Code 0000-0001 starts oscillator
// - Display drive off/on codes, off at reset
// - Time base output disable/enable, off at reset
// - Watchdog flag output disable/enable, off at reset
// - Tone off code stops buzzer outputs
// - 4kHz and 2kHz tone start codes
// - Clear time base count command
// - Clear watchdog stage count command
// - Internal or external clock select, internal default
// - Interrupt output disable/enable, disabled at reset
// - Eight rates 1Hz to 128Hz, 128Hz default
// - Test mode forbidden, normal mode default; code 1110-0000 still sets test mode
// - All rates derived from 32kHz system clock
// - Chip select high ends frame and mode
// - Watchdog time-out holds interrupt low until cleared
// - Shared divide-by-256 prescaler before rate select
package lcdsc_pkg;
	localparam logic [2:0] LCDSC_ID_READ  = 3'h6;
	localparam logic [2:0] LCDSC_ID_WRITE = 3'h5;
	localparam logic [2:0] LCDSC_ID_CMD   = 3'h4;
	localparam int         LCDSC_ADDR_W   = 7;
	localparam int         LCDSC_DATA_W   = 4;
	localparam int         LCDSC_CMD_W    = 9;
	localparam int         LCDSC_DEPTH    = 128;
	localparam int         LCDSC_PRESCALE = 256;
	localparam logic [2:0] LCDSC_RATE_RST = 3'h7;
	// Host strobe half period: 3.5 us, meets the 5 V strobe widths
	localparam int         LCDSC_CLK_MHZ  = 125;
	localparam int         LCDSC_HALF_NS  = 3500;
	localparam int         LCDSC_HALF_CYC = LCDSC_HALF_NS * LCDSC_CLK_MHZ
		/ 1000;
	localparam logic [7:0] LCDSC_C_STOP   = 8'h00;
	localparam logic [7:0] LCDSC_C_START  = 8'h01;
	localparam logic [7:0] LCDSC_C_DOFF   = 8'h02;
	localparam logic [7:0] LCDSC_C_DON    = 8'h03;
	localparam logic [7:0] LCDSC_C_TBDIS  = 8'h04;
	localparam logic [7:0] LCDSC_C_WDDIS  = 8'h05;
	localparam logic [7:0] LCDSC_C_TBEN   = 8'h06;
	localparam logic [7:0] LCDSC_C_WDEN   = 8'h07;
	localparam logic [7:0] LCDSC_C_TOFF   = 8'h08;
	localparam logic [7:0] LCDSC_C_TBCLR  = 8'h0D;
	localparam logic [7:0] LCDSC_C_WDCLR  = 8'h0F;
	localparam logic [7:0] LCDSC_C_TEST   = 8'hE0;
	localparam logic [7:0] LCDSC_C_NORM   = 8'hE3;
endpackage

// ---- shared/lcdsc_if.sv ----
`timescale 1ns/1ps
interface lcdsc_if;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic data_host_o;
	logic data_host_oe;
	logic data_dev_o;
	logic data_dev_oe;
	logic data;
	assign data = data_dev_oe ? data_dev_o :
		(data_host_oe ? data_host_o : 1'b1);
	modport dev (input cs_n, input wr_n, input rd_n, input data,
		output data_dev_o, output data_dev_oe);
	modport host (output cs_n, output wr_n, output rd_n, input data,
		output data_host_o, output data_host_oe);
endinterface

// ---- rtl/lcdsc_host.sv ----
`timescale 1ns/1ps
module lcdsc_host
	import lcdsc_pkg::*;
(
	// Clock and reset
	input  wire logic       CLK_I,
	input  wire logic       RST_I,
	input  wire logic       CE_I,
	// Request
	input  wire logic       REQ_I,
	input  wire logic [1:0] OP_I,
	input  wire logic [6:0] ADDR_I,
	input  wire logic [3:0] WDATA_I,
	input  wire logic [8:0] CMD_I,
	output logic            BUSY_O,
	output logic            DONE_O,
	output logic [3:0]      RDATA_O,
	// Link
	lcdsc_if.host           LINK
);
	// OP_I: 0 read, 1 write, 2 command, 3 read-modify-write
	typedef enum {S_IDLE, S_LO, S_HI, S_END} lcdsc_hst_t;
	lcdsc_hst_t  st_q;
	logic [22:0] sh_q;
	logic [4:0]  n_q;
	logic [4:0]  rd_at_q;
	logic [1:0]  op_q;
	logic [11:0] cnt_q;
	logic [3:0]  rd_q;
	logic        d_s1_q;
	logic        d_s2_q;
	logic        half;
	assign half = (cnt_q == 12'(LCDSC_HALF_CYC - 1));
	assign BUSY_O = (st_q != S_IDLE);
	// Read slots: the four bits after id+address come back from the device
	function automatic logic is_rd(input logic [1:0] op, input logic [4:0] k,
			input logic [4:0] at);
		is_rd = (op == 2'h0 || op == 2'h3) && k >= at && k < at + 5'h4;
	endfunction
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			d_s1_q <= 1'b1;
			d_s2_q <= 1'b1;
		end else if (CE_I) begin
			d_s1_q <= LINK.data;
			d_s2_q <= d_s1_q;
		end
	end
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st_q <= S_IDLE;
			cnt_q <= 12'h000;
			n_q <= 5'h00;
			sh_q <= '0;
			op_q <= 2'h0;
			rd_at_q <= 5'h00;
			rd_q <= 4'h0;
			DONE_O <= 1'b0;
			RDATA_O <= 4'h0;
			LINK.cs_n <= 1'b1;
			LINK.wr_n <= 1'b1;
			LINK.rd_n <= 1'b1;
			LINK.data_host_o <= 1'b1;
			LINK.data_host_oe <= 1'b0;
		end else if (CE_I) begin
			DONE_O <= 1'b0;
			cnt_q <= half ? 12'h000 : cnt_q + 12'h001;
			case (st_q)
			S_IDLE: begin
				cnt_q <= 12'h000;
				if (REQ_I) begin
					op_q <= OP_I;
					rd_at_q <= 5'd10;
					LINK.cs_n <= 1'b0;
					n_q <= 5'h00;
					st_q <= S_LO;
					case (OP_I)
					2'h0: sh_q <= {LCDSC_ID_READ, ADDR_I, 13'h0000};
					2'h1: sh_q <= {LCDSC_ID_WRITE, ADDR_I,
						WDATA_I[0], WDATA_I[1], WDATA_I[2], WDATA_I[3],
						9'h000};
					2'h3: sh_q <= {LCDSC_ID_WRITE, ADDR_I, 4'h0,
						WDATA_I[0], WDATA_I[1], WDATA_I[2], WDATA_I[3],
						5'h00};
					default: sh_q <= {LCDSC_ID_CMD, CMD_I, 11'h000};
					endcase
				end
			end
			S_LO: if (half) begin
				if (is_rd(op_q, n_q, rd_at_q)) begin
					LINK.rd_n <= 1'b0;
					LINK.data_host_oe <= 1'b0;
				end else begin
					LINK.wr_n <= 1'b0;
					LINK.data_host_oe <= 1'b1;
					LINK.data_host_o <= sh_q[22];
				end
				st_q <= S_HI;
			end
			S_HI: if (half) begin
				if (is_rd(op_q, n_q, rd_at_q))
					rd_q <= {d_s2_q, rd_q[3:1]};
				LINK.wr_n <= 1'b1;
				LINK.rd_n <= 1'b1;
				sh_q <= {sh_q[21:0], 1'b0};
				n_q <= n_q + 5'h01;
				if (n_q == ((op_q == 2'h2) ? 5'd11 :
					(op_q == 2'h3) ? 5'd17 : 5'd13))
					st_q <= S_END;
				else
					st_q <= S_LO;
			end
			S_END: if (half) begin
				LINK.cs_n <= 1'b1;
				LINK.data_host_oe <= 1'b0;
				RDATA_O <= rd_q;
				DONE_O <= 1'b1;
				st_q <= S_IDLE;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

// ---- rtl/lcdsc_dev.sv ----
`timescale 1ns/1ps
module lcdsc_dev
	import lcdsc_pkg::*;
(
	// Clock and reset
	input  wire logic CLK_I,
	input  wire logic RST_I,
	input  wire logic CE_I,
	// 32 kHz system clock tick from the selected source
	input  wire logic SYS_TICK_I,
	// Link
	lcdsc_if.dev      LINK,
	// Status
	output logic      OSC_ON_O,
	output logic      BIAS_ON_O,
	output logic      DISPLAY_ON_O,
	output logic      EXT_CLK_SEL_O,
	output logic      TEST_MODE_O,
	output logic      TIMEBASE_O,
	output logic      IRQ_N_O,
	output logic      BUZZER_DRIVE_O,
	output logic      BUZZER_DRIVE_N_O
);
	typedef enum {D_ID, D_ADDR, D_DATA, D_CMD} lcdsc_dst_t;
	lcdsc_dst_t  st_q;
	logic [3:0]  mem [LCDSC_DEPTH];
	logic [2:0]  s_cs_q;
	logic [2:0]  s_wr_q;
	logic [2:0]  s_rd_q;
	logic [1:0]  s_d_q;
	logic [8:0]  sh_q;
	logic [3:0]  n_q;
	logic [2:0]  id_q;
	logic [6:0]  addr_q;
	logic        cmd_v;
	logic [8:0]  cmd_w;
	logic        wr_rise;
	logic        rd_fall;
	logic        tb_en_q;
	logic        wd_en_q;
	logic        irq_en_q;
	logic        tone_on_q;
	logic        tone_lo_q;
	logic [2:0]  rate_q;
	logic [7:0]  pre_q;
	logic [7:0]  tb_q;
	logic [2:0]  wd_q;
	logic        wd_flag_q;
	logic [3:0]  tone_q;
	logic        pre_tick;
	logic        tb_tick;
	logic        wd_clr;
	logic        interrupt_out_disable;
	logic [7:0]  tb_vec;
	// Pin sampling; first stage read only by the second
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			s_cs_q <= 3'h7;
			s_wr_q <= 3'h7;
			s_rd_q <= 3'h7;
			s_d_q <= 2'h3;
		end else if (CE_I) begin
			s_cs_q <= {s_cs_q[1:0], LINK.cs_n};
			s_wr_q <= {s_wr_q[1:0], LINK.wr_n};
			s_rd_q <= {s_rd_q[1:0], LINK.rd_n};
			s_d_q <= {s_d_q[0], LINK.data};
		end
	end
	assign wr_rise = ~s_cs_q[1] & s_wr_q[1] & ~s_wr_q[2];
	assign rd_fall = ~s_cs_q[1] & ~s_rd_q[1] & s_rd_q[2];
	assign cmd_v = wr_rise && st_q == D_CMD && n_q == 4'd8;
	assign cmd_w = {sh_q[7:0], s_d_q[1]};
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st_q <= D_ID;
			n_q <= 4'h0;
			sh_q <= 9'h000;
			id_q <= 3'h0;
			addr_q <= 7'h00;
		end else if (CE_I) begin
			if (s_cs_q[1]) begin
				st_q <= D_ID;
				n_q <= 4'h0;
			end else if (rd_fall && st_q == D_DATA) begin
				n_q <= n_q + 4'h1;
				if (n_q == 4'd3) begin
					n_q <= 4'h0;
					// Read-modify-write stores back at the same address
					if (id_q == LCDSC_ID_READ)
						addr_q <= addr_q + 7'h01;
				end
			end else if (wr_rise) begin
				sh_q <= {sh_q[7:0], s_d_q[1]};
				n_q <= n_q + 4'h1;
				case (st_q)
				D_ID: if (n_q == 4'd2) begin
					n_q <= 4'h0;
					id_q <= {sh_q[1:0], s_d_q[1]};
					if ({sh_q[1:0], s_d_q[1]} == LCDSC_ID_CMD)
						st_q <= D_CMD;
					else if ({sh_q[1:0], s_d_q[1]} == LCDSC_ID_READ ||
						{sh_q[1:0], s_d_q[1]} == LCDSC_ID_WRITE)
						st_q <= D_ADDR;
				end
				D_ADDR: if (n_q == 4'd6) begin
					n_q <= 4'h0;
					addr_q <= {sh_q[5:0], s_d_q[1]};
					st_q <= D_DATA;
				end
				D_DATA: begin
					mem[addr_q][n_q[1:0]] <= s_d_q[1];
					if (n_q == 4'd3) begin
						n_q <= 4'h0;
						addr_q <= addr_q + 7'h01;
					end
				end
				D_CMD: if (n_q == 4'd8)
					n_q <= 4'h0;
				default: st_q <= D_ID;
				endcase
			end
		end
	end
	// Read data, lowest bit first, on each read strobe low phase
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			LINK.data_dev_o <= 1'b1;
			LINK.data_dev_oe <= 1'b0;
		end else if (CE_I) begin
			if (s_cs_q[1])
				LINK.data_dev_oe <= 1'b0;
			else if (rd_fall && st_q == D_DATA) begin
				LINK.data_dev_o <= mem[addr_q][n_q[1:0]];
				LINK.data_dev_oe <= 1'b1;
			end else if (s_rd_q[1])
				LINK.data_dev_oe <= 1'b0;
		end
	end
	// Command decode; X bits never compared
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			OSC_ON_O <= 1'b1;
			BIAS_ON_O <= 1'b1;
			DISPLAY_ON_O <= 1'b0;
			tb_en_q <= 1'b0;
			wd_en_q <= 1'b0;
			tone_on_q <= 1'b0;
			tone_lo_q <= 1'b0;
			EXT_CLK_SEL_O <= 1'b0;
			irq_en_q <= 1'b0;
			rate_q <= LCDSC_RATE_RST;
			TEST_MODE_O <= 1'b0;
		end else if (CE_I && cmd_v) begin
			case (cmd_w[8:1])
			LCDSC_C_STOP: begin
				OSC_ON_O <= 1'b0;
				BIAS_ON_O <= 1'b0;
			end
			LCDSC_C_START: begin
				OSC_ON_O <= 1'b1;
				BIAS_ON_O <= 1'b1;
			end
			LCDSC_C_DOFF: DISPLAY_ON_O <= 1'b0;
			LCDSC_C_DON: DISPLAY_ON_O <= 1'b1;
			LCDSC_C_TBDIS: tb_en_q <= 1'b0;
			LCDSC_C_TBEN: tb_en_q <= 1'b1;
			LCDSC_C_WDDIS: wd_en_q <= 1'b0;
			LCDSC_C_WDEN: wd_en_q <= 1'b1;
			LCDSC_C_TOFF: tone_on_q <= 1'b0;
			LCDSC_C_TEST: TEST_MODE_O <= 1'b1;
			LCDSC_C_NORM: TEST_MODE_O <= 1'b0;
			default: begin
				if (cmd_w[8:4] == 5'h03)
					EXT_CLK_SEL_O <= cmd_w[3];
				if (cmd_w[8:6] == 3'h2) begin
					tone_on_q <= 1'b1;
					tone_lo_q <= 1'b0;
				end
				if (cmd_w[8:5] == 4'h6) begin
					tone_on_q <= 1'b1;
					tone_lo_q <= 1'b1;
				end
				if (cmd_w[8:6] == 3'h4)
					irq_en_q <= cmd_w[4];
				if (cmd_w[8:6] == 3'h5 && !cmd_w[4])
					rate_q <= cmd_w[3:1];
			end
			endcase
		end
	end
	// Timers: prescaler /256 from system tick
	assign pre_tick = SYS_TICK_I && pre_q == 8'(LCDSC_PRESCALE - 1);
	assign tb_tick = pre_tick && (tb_q | (8'hFF << (3'h7 - rate_q))) == 8'hFF;
	// Prescaler top bit is the 128 Hz square wave
	assign tb_vec = {tb_q[6:0], pre_q[7]};
	assign wd_clr = cmd_v && cmd_w[8:1] == LCDSC_C_WDCLR;
	assign interrupt_out_disable = cmd_v && cmd_w[8:6] == 3'h4 && !cmd_w[4];
	always_ff @(posedge CLK_I) begin
		if (RST_I)
			pre_q <= 8'h00;
		else if (CE_I && SYS_TICK_I)
			pre_q <= pre_q + 8'h01;
	end
	always_ff @(posedge CLK_I) begin
		if (RST_I)
			tb_q <= 8'h00;
		else if (CE_I) begin
			if (cmd_v && cmd_w[8:1] == LCDSC_C_TBCLR)
				tb_q <= 8'h00;
			else if (pre_tick)
				tb_q <= tb_q + 8'h01;
		end
	end
	// Time base output at selected rate (toggles, 128 Hz to 1 Hz)
	always_ff @(posedge CLK_I) begin
		if (RST_I)
			TIMEBASE_O <= 1'b0;
		else if (CE_I)
			TIMEBASE_O <= tb_en_q & tb_vec[3'h7 - rate_q];
	end
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			wd_q <= 3'h0;
			wd_flag_q <= 1'b0;
		end else if (CE_I) begin
			if (wd_clr)
				wd_q <= 3'h0;
			else if (tb_tick && wd_en_q)
				wd_q <= wd_q + 3'h1;
			// Time-out beats an interrupt disable in the same cycle
			if (tb_tick && wd_en_q && wd_q == 3'h3 && !wd_clr)
				wd_flag_q <= 1'b1;
			else if (wd_clr || interrupt_out_disable)
				wd_flag_q <= 1'b0;
		end
	end
	always_ff @(posedge CLK_I) begin
		if (RST_I)
			IRQ_N_O <= 1'b1;
		else if (CE_I)
			IRQ_N_O <= ~(irq_en_q & wd_flag_q);
	end
	// Tone: /8 gives 4 kHz, /16 gives 2 kHz
	always_ff @(posedge CLK_I) begin
		if (RST_I)
			tone_q <= 4'h0;
		else if (CE_I && SYS_TICK_I)
			tone_q <= tone_q + 4'h1;
	end
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			BUZZER_DRIVE_O <= 1'b0;
			BUZZER_DRIVE_N_O <= 1'b0;
		end else if (CE_I) begin
			BUZZER_DRIVE_O <= tone_on_q &
				(tone_lo_q ? tone_q[3] : tone_q[2]);
			BUZZER_DRIVE_N_O <= tone_on_q &
				~(tone_lo_q ? tone_q[3] : tone_q[2]);
		end
	end
endmodule

// ---- tb/lcdsc_props.sv ----
`timescale 1ns/1ps
module lcdsc_props
	import lcdsc_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Link signals
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic data_host_o,
	input wire logic data_host_oe,
	input wire logic data_dev_o,
	input wire logic data_dev_oe,
	input wire logic data
);
	logic [7:0] nw_q;
	logic [7:0] nr_q;
	logic [2:0] id_q;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// Strobe counts and mode bits of the open frame
	always_ff @(posedge CLK_I) begin
		if (RST_I || cs_n) begin
			nw_q <= 8'h00;
			nr_q <= 8'h00;
			id_q <= 3'h0;
		end else begin
			if ($fell(wr_n)) begin
				nw_q <= nw_q + 8'h01;
				if (nw_q < 8'h03)
					id_q <= {id_q[1:0], data};
			end
			if ($fell(rd_n))
				nr_q <= nr_q + 8'h01;
		end
	end
	one_driver_a: assert property (!(data_dev_oe && data_host_oe))
		else $error("both ends drive data");
	strobe_excl_a: assert property (!(!wr_n && !rd_n))
		else $error("write and read strobe low together");
	wr_frame_a: assert property (!wr_n |-> !cs_n)
		else $error("write strobe outside frame");
	dev_frame_a: assert property (data_dev_oe |-> !cs_n)
		else $error("device drives data outside frame");
	data_hold_a: assert property ((!wr_n && !$past(wr_n))
		|-> $stable(data_host_o)) else $error("data moved in strobe");
	wr_width_a: assert property ($fell(wr_n) |-> (!wr_n) [*8])
		else $error("write strobe too short");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("chip select gap too short");
	rd_answer_a: assert property ($fell(rd_n) |-> ##[1:8] data_dev_oe)
		else $error("no read answer");
	frame_len_a: assert property ($rose(cs_n) |->
		(nw_q == 8'h0A && nr_q == 8'h04) || (nw_q == 8'h0C && nr_q == 8'h00)
		|| (nw_q == 8'h0E && (nr_q == 8'h00 || nr_q == 8'h04)))
		else $error("bad frame length");
	mode_id_a: assert property ($rose(cs_n) |->
		(id_q == LCDSC_ID_READ && nw_q == 8'h0A)
		|| (id_q == LCDSC_ID_CMD && nw_q == 8'h0C)
		|| (id_q == LCDSC_ID_WRITE && nw_q == 8'h0E))
		else $error("bad mode identifier");
endmodule

// ---- tb/tb_lcd_serial_command_decoder.sv ----
`timescale 1ns/1ps
module tb_lcd_serial_command_decoder;
	import lcdsc_pkg::*;
	logic       clk, rst, req, busy, done, tbo, irq_n, bz, bz_n, wq;
	logic       m_tb, m_irq, m_wd;
	logic [1:0] op;
	logic [6:0] addr;
	logic [3:0] wdat, rdat, d1, d2;
	logic [8:0] cmd;
	logic [4:0] st, m;
	logic [7:0] nb, lb;
	logic [2:0] id, lid;
	logic [3:0] mem[int];
	logic [7:0] codes[15] = '{8'h03, 8'hE0, 8'hE3, 8'h1C, 8'h18, 8'h00,
		8'h01, 8'h06, 8'h40, 8'h60, 8'h08, 8'h07, 8'h88, 8'h80, 8'hFF};
	logic [7:0] masks[15] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00,
		8'h00, 8'h00, 8'h1F, 8'h0F, 8'h00, 8'h00, 8'h17, 8'h17, 8'h00};
	int         num_errors, check_count, m_tone;
	lcdsc_if link();
	lcdsc_host lcdsc_host_inst(.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
		.REQ_I(req), .OP_I(op), .ADDR_I(addr), .WDATA_I(wdat), .CMD_I(cmd),
		.BUSY_O(busy), .DONE_O(done), .RDATA_O(rdat), .LINK(link.host));
	lcdsc_dev lcdsc_dev_inst(.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
		.SYS_TICK_I(1'b1), .LINK(link.dev), .OSC_ON_O(st[4]),
		.BIAS_ON_O(st[3]), .DISPLAY_ON_O(st[2]), .EXT_CLK_SEL_O(st[1]),
		.TEST_MODE_O(st[0]), .TIMEBASE_O(tbo), .IRQ_N_O(irq_n),
		.BUZZER_DRIVE_O(bz), .BUZZER_DRIVE_N_O(bz_n));
	lcdsc_props lcdsc_props_inst(.CLK_I(clk), .RST_I(rst),
		.cs_n(link.cs_n), .wr_n(link.wr_n), .rd_n(link.rd_n),
		.data_host_o(link.data_host_o), .data_host_oe(link.data_host_oe),
		.data_dev_o(link.data_dev_o), .data_dev_oe(link.data_dev_oe),
		.data(link.data));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// Host-written bits and mode of the last frame on the wire
	always @(posedge clk) begin
		wq <= link.wr_n;
		if (link.cs_n) begin
			if (nb != 0) begin
				lb <= nb;
				lid <= id;
			end
			nb <= 0;
		end else if (wq && !link.wr_n) begin
			nb <= nb + 8'h01;
			if (nb < 3)
				id <= {id[1:0], link.data};
		end
	end
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic xfer(logic [1:0] o, logic [6:0] a, logic [3:0] d,
		logic [8:0] c, logic [7:0] bits, logic [2:0] i);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1;
		op <= o;
		addr <= a;
		wdat <= d;
		cmd <= c;
		@(posedge clk);
		req <= 0;
		while (done !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 100000) begin
				num_errors++;
				$display("Error done expected 1 seen 0");
				results();
			end
		end
		repeat (20) @(negedge clk);
		check("bits", lb, bits);
		check("id", 8'(lid), 8'(i));
	endtask
	task automatic cmdt(logic [7:0] c);
		int t, b, n;
		logic p, pb;
		t = 0;
		b = 0;
		n = 0;
		casez (c)
			8'h00: m[4:3] = 2'b00;
			8'h01: m[4:3] = 2'b11;
			8'h02: m[2] = 0;
			8'h03: m[2] = 1;
			8'h04: m_tb = 0;
			8'h06: m_tb = 1;
			8'h05: m_wd = 0;
			8'h07: m_wd = 1;
			8'h08: m_tone = 0;
			8'b0001_10??: m[1] = 0;
			8'b0001_11??: m[1] = 1;
			8'b010?_????: m_tone = 128;
			8'b0110_????: m_tone = 64;
			8'b100?_0???: m_irq = 0;
			8'b100?_1???: m_irq = 1;
			8'hE0: m[0] = 1;
			8'hE3: m[0] = 0;
			default: ;
		endcase
		xfer(2'h2, 7'h00, 4'h0, {c, 1'($urandom)}, 8'h0C, LCDSC_ID_CMD);
		check("status", 8'(st), 8'(m));
		p = tbo;
		pb = bz;
		repeat (1200) begin
			@(negedge clk);
			t += int'(tbo !== p);
			b += int'(bz === 1'b1 && pb === 1'b0);
			n += int'(irq_n === 1'b0);
			p = tbo;
			pb = bz;
		end
		check("timebase", 8'(t > 0), 8'(m_tb));
		check("tone", 8'(b >= m_tone * 75 / 64 - 4
			&& b <= m_tone * 75 / 64 + 4), 8'h01);
		check("irq", 8'(n > 0), 8'(m_irq && m_wd));
		$display("command %0h done", c);
	endtask
	initial begin
		rst = 1;
		req = 0;
		op = 0;
		addr = 0;
		wdat = 0;
		cmd = 0;
		wq = 1;
		nb = 0;
		lb = 0;
		id = 0;
		lid = 0;
		m = 5'b11000;
		m_tb = 0;
		m_irq = 0;
		m_wd = 0;
		m_tone = 0;
		void'($urandom(10315));
		repeat (10) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		check("reset", 8'(st), 8'(m));
		check("outputs", {tbo, irq_n, bz, bz_n}, 8'h04);
		$display("reset test done");
		foreach (codes[k])
			cmdt(codes[k] | (8'($urandom) & masks[k]));
		d1 = 4'($urandom);
		d2 = ~d1;
		xfer(2'h1, 7'h7F, d1, 9'h000, 8'h0E, LCDSC_ID_WRITE);
		mem[127] = d1;
		xfer(2'h3, 7'h7F, d2, 9'h000, 8'h0E, LCDSC_ID_WRITE);
		check("rmw", 8'(rdat), 8'(mem[127]));
		mem[127] = d2;
		xfer(2'h0, 7'h7F, 4'h0, 9'h000, 8'h0A, LCDSC_ID_READ);
		check("read", 8'(rdat), 8'(mem[127]));
		$display("data test done");
		results();
	end
endmodule
